// *** nfc_frame_rx_config_bench.sv ***
`timescale 1ns/10ps
module nfc_frame_rx_config_bench;
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       tx_s = 1'b0;
	logic       tx_e = 1'b0;
	logic       tx_v = 1'b0;
	logic [7:0] tx_b = 8'h00;
	logic [2:0] tx_rate = 3'h4;
	logic       rx_start = 1'b0;
	logic       crc_en = 1'b0;
	logic [1:0] esr = 2'h0;
	logic [7:0] err_reg = 8'h5A;
	logic       sof, sub, bv, par, coll, fend, guard;
	logic       sym_v, tpar, tpv, tdv, rx_en, eofc, eofb, fwr, flush, perr, prot, done, irq;
	logic [7:0] rb, rdata, tdat, fwd;
	logic [2:0] bits, baud;
	logic [1:0] sym;
	logic [7:0] fq[$];
	int         n_fail = 0;
	int         samples_checked = 0;
	int         ndone = 0, nflush = 0, nirq = 0, nprot = 0, nperr = 0, n0;

	always #2.5 clk_i = ~clk_i;

	nfcfr_framer #(.EGT_LIMIT_CYC(20)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .tx_frame_start_i(tx_s), .tx_byte_valid_i(tx_v),
		.tx_byte_i(tx_b), .tx_frame_end_i(tx_e), .tx_rate_i(tx_rate), .tx_symbol_o(sym),
		.tx_symbol_valid_o(sym_v), .tx_data_o(tdat), .tx_parity_o(tpar),
		.tx_parity_valid_o(tpv), .tx_data_valid_o(tdv), .rx_start_i(rx_start),
		.crc_enable_i(crc_en), .end_symbol_register_i(esr), .rx_sof_i(sof),
		.rx_subcarrier_i(sub), .rx_byte_valid_i(bv), .rx_byte_i(rb), .rx_parity_i(par),
		.rx_collision_i(coll), .rx_frame_end_i(fend), .rx_bits_i(bits), .rx_guard_i(guard),
		.error_reg_i(err_reg), .rx_enable_o(rx_en), .rx_baud_o(baud), .eof_check_o(eofc),
		.eof_type_b_o(eofb), .fifo_wr_o(fwr), .fifo_wdata_o(fwd), .fifo_flush_o(flush),
		.rx_parity_err_o(perr), .protocol_err_o(prot), .rx_done_irq_o(done),
		.rx_frame_start_irq_o(irq));

	nfcfr_card_model u_card (.clk_i(clk_i), .sof_o(sof), .sub_o(sub), .byte_valid_o(bv),
		.byte_o(rb), .parity_o(par), .coll_o(coll), .end_o(fend), .bits_o(bits),
		.guard_o(guard));

	// ----
	// Receive side monitor
	// ----
	always @(posedge clk_i) begin
		if (fwr === 1'b1) fq.push_back(fwd);
		if (flush === 1'b1) fq.delete();
		ndone += int'(done === 1'b1);
		nflush += int'(flush === 1'b1);
		nirq += int'(irq === 1'b1);
		nprot += int'(prot === 1'b1);
		nperr += int'(perr === 1'b1);
	end

	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk("register", rdata, exp);
	endtask
	task automatic txp(input logic s, input logic e, input logic [7:0] b);
		@(posedge clk_i);
		tx_s <= s;
		tx_e <= e;
		tx_v <= !s && !e;
		tx_b <= b;
		@(posedge clk_i);
		{tx_s, tx_e, tx_v} <= 3'h0;
		#1;
	endtask
	task automatic cmpq(input logic [7:0] e[$]);
		chk("fifo count", 8'(fq.size()), 8'(e.size()));
		foreach (e[k]) if (k < fq.size()) chk("fifo byte", fq[k], e[k]);
		fq.delete();
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		wrap_up();
	end

	// ----
	// Tests
	// ----
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int a = 8'h33; a < 8'h37; a++) rreg(8'(a), 8'h00);
		chk("baud reset", 8'(baud), 8'h00);
		wreg(8'h33, 8'hFF); rreg(8'h33, 8'hCF);
		wreg(8'h34, 8'hFF); rreg(8'h34, 8'h24);
		wreg(8'h35, 8'hFF); rreg(8'h35, 8'hFF);
		wreg(8'h36, 8'hFF); rreg(8'h36, 8'hFF);
		wreg(8'h37, 8'hFF); rreg(8'h37, 8'h00);
		wreg(8'h36, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wreg(8'h33, 8'h80 | 8'(i << 2) | 8'(3 - i));
			txp(1'b1, 1'b0, 8'h00);
			chk("start valid", 8'(sym_v), 8'(i != 3));
			if (i != 3) chk("start code", 8'(sym), 8'(3 - i));
			txp(1'b0, 1'b0, 8'hA5 + 8'(i));
			chk("tx byte", tdat, 8'hA5 + 8'(i));
			chk("tx parity", {tpv, tdv, 5'h00, tpar}, {7'h60, ~^(8'hA5 + 8'(i))});
			txp(1'b0, 1'b1, 8'h00);
			chk("stop valid", 8'(sym_v), 8'(i != 0));
			if (i != 0) chk("stop code", 8'(sym), 8'(i));
		end
		wreg(8'h33, 8'h00);
		txp(1'b0, 1'b0, 8'h3C);
		chk("no parity", {tpv, tdv}, 8'h01);
		$display("test transmit done");
		wreg(8'h36, 8'h03);
		txp(1'b0, 1'b1, 8'h00);
		repeat (600) @(posedge clk_i);
		#1 chk("dead carrier", 8'(rx_en), 8'h00);
		repeat (200) @(posedge clk_i);
		#1 chk("live carrier", 8'(rx_en), 8'h01);
		tx_rate <= 3'h7;
		wreg(8'h36, 8'h83);
		txp(1'b0, 1'b1, 8'h00);
		repeat (300) @(posedge clk_i);
		#1 chk("dead half bit", 8'(rx_en), 8'h00);
		repeat (100) @(posedge clk_i);
		#1 chk("live half bit", 8'(rx_en), 8'h01);
		$display("test dead time done");
		crc_en <= 1'b1;
		wreg(8'h33, 8'h40);
		wreg(8'h35, 8'hC4);
		u_card.send(8'h11, 1'b0);
		u_card.send(8'h22, 1'b1);
		u_card.send(8'h33, 1'b0);
		u_card.fin(3'h3, 8'h07);
		repeat (4) @(posedge clk_i);
		cmpq('{8'h11, 8'h22, 8'h33, 8'h07, 8'h5A});
		chk("parity errors", 8'(nperr), 8'h01);
		chk("done count", 8'(ndone), 8'h01);
		chk("still on", 8'(rx_en), 8'h01);
		$display("test multi receive done");
		crc_en <= 1'b0;
		wreg(8'h35, 8'h4C);
		u_card.sof();
		u_card.send(8'h01, 1'b0);
		u_card.coll();
		u_card.sof();
		u_card.send(8'h02, 1'b0);
		u_card.send(8'h03, 1'b0);
		u_card.fin(3'h0, 8'h00);
		repeat (4) @(posedge clk_i);
		chk("flushed", 8'(fq.size()), 8'h00);
		chk("flush count", 8'(nflush), 8'h02);
		chk("no done", 8'(ndone), 8'h01);
		err_reg <= 8'hC3;
		u_card.sof();
		u_card.send(8'hA1, 1'b0);
		u_card.send(8'hA2, 1'b0);
		u_card.send(8'hA3, 1'b0);
		u_card.fin(3'h5, 8'h1B);
		repeat (4) @(posedge clk_i);
		cmpq('{8'hA1, 8'hA2, 8'hA3, 8'h1B, 8'hC3});
		chk("done after", 8'(ndone), 8'h02);
		$display("test suppression done");
		wreg(8'h34, 8'h24);
		#1 n0 = nirq;
		u_card.sub(1'b1);
		repeat (3) @(posedge clk_i);
		rreg(8'h34, 8'h27);
		chk("sub irq", 8'(nirq - n0), 8'h01);
		u_card.sub(1'b0);
		repeat (2) @(posedge clk_i);
		rreg(8'h34, 8'h26);
		wreg(8'h34, 8'h24); rreg(8'h34, 8'h24);
		u_card.sof();
		repeat (2) @(posedge clk_i);
		rreg(8'h34, 8'h34);
		chk("sof irq", 8'(nirq - n0), 8'h02);
		wreg(8'h34, 8'h00);
		u_card.sub(1'b1);
		u_card.sof();
		repeat (3) @(posedge clk_i);
		rreg(8'h34, 8'h13);
		chk("masked irq", 8'(nirq - n0), 8'h02);
		u_card.sub(1'b0);
		$display("test detection done");
		for (int c = 4; c < 8; c++) begin
			wreg(8'h35, 8'h30 | 8'(c));
			repeat (2) @(posedge clk_i);
			#1 chk("baud", 8'(baud), 8'(c));
		end
		chk("eof type b", {eofb, eofc}, 8'h03);
		u_card.guard(25);
		repeat (3) @(posedge clk_i);
		chk("guard error", 8'(nprot), 8'h01);
		wreg(8'h35, 8'h04);
		repeat (2) @(posedge clk_i);
		#1 chk("eof off", {eofb, eofc}, 8'h00);
		esr <= 2'h2;
		repeat (2) @(posedge clk_i);
		#1 chk("eof symbol", {eofb, eofc}, 8'h01);
		crc_en <= 1'b1;
		u_card.fin(3'h2, 8'h0F);
		repeat (3) @(posedge clk_i);
		#1 chk("single stops", 8'(rx_en), 8'h00);
		chk("no partial", 8'(fq.size()), 8'h00);
		rx_start <= 1'b1;
		@(posedge clk_i) rx_start <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk("restart", 8'(rx_en), 8'h01);
		$display("test end of frame done");
		wrap_up();
	end
endmodule

// *** nfcfr_asserts.sv ***
`timescale 1ns/10ps
module nfcfr_asserts #(
	parameter int EGT_LIMIT_CYC = 1000
) (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       tx_frame_start_i,
	input wire logic       tx_frame_end_i,
	input wire logic       tx_byte_valid_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic [1:0] tx_symbol_o,
	input wire logic       tx_symbol_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       tx_parity_o,
	input wire logic       tx_parity_valid_o,
	input wire logic       tx_data_valid_o,
	input wire logic       rx_sof_i,
	input wire logic       rx_subcarrier_i,
	input wire logic       rx_byte_valid_i,
	input wire logic       rx_frame_end_i,
	input wire logic       rx_guard_i,
	input wire logic       fifo_wr_o,
	input wire logic       fifo_flush_o,
	input wire logic       rx_parity_err_o,
	input wire logic       protocol_err_o,
	input wire logic       rx_done_irq_o,
	input wire logic       rx_frame_start_irq_o
);
	// ----
	// Guard time length counter
	// ----
	int gcnt;
	always_ff @(posedge clk_i) begin
		if (reset_i || !rx_guard_i) begin
			gcnt <= 0;
		end else begin
			gcnt <= gcnt + 1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	chk_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h33 || reg_addr_i > 8'h36)
		|=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_tx_byte: assert property (tx_byte_valid_i |=> tx_data_valid_o &&
		tx_data_o == $past(tx_byte_i) && tx_parity_o == ~^$past(tx_byte_i))
		else $error("sent byte or parity wrong");
	chk_parity_pair: assert property (tx_parity_valid_o |-> tx_data_valid_o)
		else $error("parity without its byte");
	chk_symbol_cause: assert property (tx_symbol_valid_o |-> tx_symbol_o != 2'h0 &&
		$past(tx_frame_start_i || tx_frame_end_i))
		else $error("symbol pulse without cause");
	chk_irq_cause: assert property (rx_frame_start_irq_o |-> $past(rx_sof_i) ||
		($past(rx_subcarrier_i) && !$past(rx_subcarrier_i, 2)))
		else $error("frame start interrupt without cause");
	chk_fifo_cause: assert property (fifo_wr_o |-> $past(rx_byte_valid_i) ||
		$past(rx_frame_end_i) || $past(rx_frame_end_i, 2))
		else $error("fifo write without cause");
	chk_done_cause: assert property (rx_done_irq_o |-> $past(rx_frame_end_i) && !fifo_flush_o)
		else $error("receive done wrong");
	chk_parity_err: assert property (rx_parity_err_o |-> $past(rx_byte_valid_i))
		else $error("parity error without byte");
	chk_guard_long: assert property (protocol_err_o |-> gcnt >= EGT_LIMIT_CYC - 1)
		else $error("guard error too early");
endmodule

bind nfcfr_framer nfcfr_asserts #(.EGT_LIMIT_CYC(EGT_LIMIT_CYC)) u_chk (.clk_i, .reset_i,
	.reg_addr_i, .reg_rd_i, .reg_rdata_o, .tx_frame_start_i, .tx_frame_end_i,
	.tx_byte_valid_i, .tx_byte_i, .tx_symbol_o, .tx_symbol_valid_o, .tx_data_o,
	.tx_parity_o, .tx_parity_valid_o, .tx_data_valid_o, .rx_sof_i, .rx_subcarrier_i,
	.rx_byte_valid_i, .rx_frame_end_i, .rx_guard_i, .fifo_wr_o, .fifo_flush_o,
	.rx_parity_err_o, .protocol_err_o, .rx_done_irq_o, .rx_frame_start_irq_o);

// *** nfcfr_card_model.sv ***
`timescale 1ns/10ps
module nfcfr_card_model (
	input  wire logic       clk_i,
	output logic            sof_o,
	output logic            sub_o,
	output logic            byte_valid_o,
	output logic      [7:0] byte_o,
	output logic            parity_o,
	output logic            coll_o,
	output logic            end_o,
	output logic      [2:0] bits_o,
	output logic            guard_o
);
	initial begin
		{sof_o, sub_o, byte_valid_o, byte_o, parity_o, coll_o, end_o, bits_o, guard_o} = '0;
	end
	task automatic sof();
		@(posedge clk_i) sof_o <= 1'b1;
		@(posedge clk_i) sof_o <= 1'b0;
	endtask
	task automatic coll();
		@(posedge clk_i) coll_o <= 1'b1;
		@(posedge clk_i) coll_o <= 1'b0;
	endtask
	task automatic sub(input logic v);
		@(posedge clk_i) sub_o <= v;
	endtask
	// Odd parity, flipped on request; released lines show the inverse
	task automatic send(input logic [7:0] b, input logic bad);
		@(posedge clk_i);
		byte_valid_o <= 1'b1;
		byte_o <= b;
		parity_o <= ~^b ^ bad;
		@(posedge clk_i);
		byte_valid_o <= 1'b0;
		byte_o <= ~b;
		parity_o <= ^b ^ bad;
	endtask
	task automatic fin(input logic [2:0] n, input logic [7:0] d);
		@(posedge clk_i);
		end_o <= 1'b1;
		bits_o <= n;
		byte_o <= d;
		@(posedge clk_i);
		end_o <= 1'b0;
		bits_o <= ~n;
		byte_o <= ~d;
	endtask
	task automatic guard(input int n);
		@(posedge clk_i) guard_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		guard_o <= 1'b0;
	endtask
endmodule

// *** nfcfr_framer.sv ***
`timescale 1ns/10ps

// Operation
// - With transmit parity enabled, append an odd parity bit to each sent byte.
// - With receive parity enabled, check parity; parity never enters the FIFO.
// - Stop select picks nothing, symbol 1, 2 or 3 after the frame.
// - Start select picks nothing, symbol 1, 2 or 3 before the frame.
// - Frame start with its enable set raises the frame start interrupt.
// - Frame start seen flag is sticky until software clears it.
// - Subcarrier with its enable set raises the same interrupt.
// - Subcarrier seen flag is sticky until software clears it.
// - Subcarrier now bit shows the live detector level.
// - Partial bits are written to the FIFO with checksum on only when the allow bit is set.
// - Multi-frame mode keeps the receiver running after each frame.
// - Multi-frame mode appends a copy of the error byte per frame.
// - End type bit selects symbol register end or type B end.
// - End check is off when type is 0 and symbol bits 1:0 are 0.
// - Guard time check in type B flags a protocol error when too long.
// - Disturbance suppress: error in first three bytes flushes FIFO.
// - Collision, or a short frame after a frame start, counts as error.
// - Disturbance error cases never raise receive complete.
// - Baud field 4h to 7h selects 106 to 847 kBd, others reserved.
// - Wait unit is 16 carrier periods or half a data bit.
// - After transmit the receiver ignores input for the wait count.
// - Half-bit unit follows the transmit data bit rate.
module nfcfr_framer #(
	parameter int EGT_LIMIT_CYC = 1000
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       tx_frame_start_i,
	input  wire logic       tx_byte_valid_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic       tx_frame_end_i,
	input  wire logic [2:0] tx_rate_i,
	output logic      [1:0] tx_symbol_o,
	output logic            tx_symbol_valid_o,
	output logic      [7:0] tx_data_o,
	output logic            tx_parity_o,
	output logic            tx_parity_valid_o,
	output logic            tx_data_valid_o,
	input  wire logic       rx_start_i,
	input  wire logic       crc_enable_i,
	input  wire logic [1:0] end_symbol_register_i,
	input  wire logic       rx_sof_i,
	input  wire logic       rx_subcarrier_i,
	input  wire logic       rx_byte_valid_i,
	input  wire logic [7:0] rx_byte_i,
	input  wire logic       rx_parity_i,
	input  wire logic       rx_collision_i,
	input  wire logic       rx_frame_end_i,
	input  wire logic [2:0] rx_bits_i,
	input  wire logic       rx_guard_i,
	input  wire logic [7:0] error_reg_i,
	output logic            rx_enable_o,
	output logic      [2:0] rx_baud_o,
	output logic            eof_check_o,
	output logic            eof_type_b_o,
	output logic            fifo_wr_o,
	output logic      [7:0] fifo_wdata_o,
	output logic            fifo_flush_o,
	output logic            rx_parity_err_o,
	output logic            protocol_err_o,
	output logic            rx_done_irq_o,
	output logic            rx_frame_start_irq_o
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] frame_format_control_reg;
	logic [7:0] rx_control_reg;
	logic [7:0] rx_dead_time_reg;
	logic       sof_irq_en_reg;
	logic       subc_irq_en_reg;
	logic       sof_seen_reg;
	logic       subc_seen_reg;
	logic       subc_last_reg;
	logic [7:0] sd_read;
	logic       wr_ff;
	logic       wr_sd;
	logic       wr_rc;
	logic       wr_dt;
	logic       subc_rise;

	assign wr_ff = reg_wr_i && (reg_addr_i == nfcfr_pkg::ADDR_FRAME_FORMAT_CONTROL);
	assign wr_sd = reg_wr_i && (reg_addr_i == nfcfr_pkg::ADDR_RX_FRAME_START_DETECT);
	assign wr_rc = reg_wr_i && (reg_addr_i == nfcfr_pkg::ADDR_RX_CONTROL);
	assign wr_dt = reg_wr_i && (reg_addr_i == nfcfr_pkg::ADDR_RX_DEAD_TIME);
	assign subc_rise = rx_subcarrier_i && !subc_last_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			frame_format_control_reg <= nfcfr_pkg::RESET_BYTE;
			rx_control_reg <= nfcfr_pkg::RESET_BYTE;
			rx_dead_time_reg <= nfcfr_pkg::RESET_BYTE;
			sof_irq_en_reg <= 1'b0;
			subc_irq_en_reg <= 1'b0;
		end else begin
			if (wr_ff) begin
				frame_format_control_reg <= reg_wdata_i & nfcfr_pkg::FF_MASK;
			end
			if (wr_rc) begin
				rx_control_reg <= reg_wdata_i;
			end
			if (wr_dt) begin
				rx_dead_time_reg <= reg_wdata_i;
			end
			if (wr_sd) begin
				sof_irq_en_reg <= reg_wdata_i[nfcfr_pkg::SD_SOF_EN];
				subc_irq_en_reg <= reg_wdata_i[nfcfr_pkg::SD_SUBCARRIER_IRQ_ENABLE];
			end
		end
	end

	// Sticky flags: detection wins over a clearing write
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sof_seen_reg <= 1'b0;
			subc_seen_reg <= 1'b0;
			subc_last_reg <= 1'b0;
		end else begin
			subc_last_reg <= rx_subcarrier_i;
			if (rx_sof_i) begin
				sof_seen_reg <= 1'b1;
			end else if (wr_sd && !reg_wdata_i[nfcfr_pkg::SD_SOF_SEEN]) begin
				sof_seen_reg <= 1'b0;
			end
			if (rx_subcarrier_i) begin
				subc_seen_reg <= 1'b1;
			end else if (wr_sd && !reg_wdata_i[nfcfr_pkg::SD_SUBC_SEEN]) begin
				subc_seen_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		sd_read = nfcfr_pkg::RESET_BYTE;
		sd_read[nfcfr_pkg::SD_SOF_EN] = sof_irq_en_reg;
		sd_read[nfcfr_pkg::SD_SOF_SEEN] = sof_seen_reg;
		sd_read[nfcfr_pkg::SD_SUBCARRIER_IRQ_ENABLE] = subc_irq_en_reg;
		sd_read[nfcfr_pkg::SD_SUBC_SEEN] = subc_seen_reg;
		sd_read[nfcfr_pkg::SD_SUBC_NOW] = rx_subcarrier_i;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= nfcfr_pkg::RESET_BYTE;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				nfcfr_pkg::ADDR_FRAME_FORMAT_CONTROL: reg_rdata_o <= frame_format_control_reg;
				nfcfr_pkg::ADDR_RX_FRAME_START_DETECT: reg_rdata_o <= sd_read;
				nfcfr_pkg::ADDR_RX_CONTROL: reg_rdata_o <= rx_control_reg;
				nfcfr_pkg::ADDR_RX_DEAD_TIME: reg_rdata_o <= rx_dead_time_reg;
				default: reg_rdata_o <= nfcfr_pkg::RESET_BYTE;
			endcase
		end else begin
			reg_rdata_o <= nfcfr_pkg::RESET_BYTE;
		end
	end

	// ----------------------------------------
	// Frame start interrupt
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_frame_start_irq_o <= 1'b0;
		end else begin
			rx_frame_start_irq_o <= (rx_sof_i && sof_irq_en_reg)
				|| (subc_rise && subc_irq_en_reg);
		end
	end

	// ----------------------------------------
	// Transmit framing
	// ----------------------------------------
	logic [1:0] start_sel;
	logic [1:0] stop_sel;

	assign start_sel = frame_format_control_reg[nfcfr_pkg::FF_START_HI:nfcfr_pkg::FF_START_LO];
	assign stop_sel = frame_format_control_reg[nfcfr_pkg::FF_STOP_HI:nfcfr_pkg::FF_STOP_LO];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_symbol_o <= nfcfr_pkg::SYM_NONE;
			tx_symbol_valid_o <= 1'b0;
		end else if (tx_frame_start_i) begin
			tx_symbol_o <= start_sel;
			tx_symbol_valid_o <= (start_sel != nfcfr_pkg::SYM_NONE);
		end else if (tx_frame_end_i) begin
			tx_symbol_o <= stop_sel;
			tx_symbol_valid_o <= (stop_sel != nfcfr_pkg::SYM_NONE);
		end else begin
			tx_symbol_o <= nfcfr_pkg::SYM_NONE;
			tx_symbol_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_data_o <= nfcfr_pkg::RESET_BYTE;
			tx_parity_o <= 1'b0;
			tx_parity_valid_o <= 1'b0;
			tx_data_valid_o <= 1'b0;
		end else begin
			tx_data_valid_o <= tx_byte_valid_i;
			tx_parity_valid_o <= tx_byte_valid_i
				&& frame_format_control_reg[nfcfr_pkg::FF_TX_PAR];
			if (tx_byte_valid_i) begin
				tx_data_o <= tx_byte_i;
				tx_parity_o <= ~(^tx_byte_i);
			end
		end
	end

	// ----------------------------------------
	// Receiver dead time
	// ----------------------------------------
	nfcfr_pkg::nfcfr_rx_state_t state_reg;
	logic [nfcfr_pkg::PRESCALE_W-1:0] unit_len;
	logic [nfcfr_pkg::PRESCALE_W-1:0] prescale_reg;
	logic [6:0] dead_cnt_reg;
	logic       unit_tick;

	always_comb begin
		unit_len = nfcfr_pkg::PRESCALE_W'(nfcfr_pkg::UNIT16_CYC);
		if (rx_dead_time_reg[nfcfr_pkg::DT_UNIT]) begin
			unique case (tx_rate_i)
				nfcfr_pkg::BAUD_212: unit_len = nfcfr_pkg::PRESCALE_W'(nfcfr_pkg::HALF_212_CYC);
				nfcfr_pkg::BAUD_424: unit_len = nfcfr_pkg::PRESCALE_W'(nfcfr_pkg::HALF_424_CYC);
				nfcfr_pkg::BAUD_847: unit_len = nfcfr_pkg::PRESCALE_W'(nfcfr_pkg::HALF_847_CYC);
				default: unit_len = nfcfr_pkg::PRESCALE_W'(nfcfr_pkg::HALF_106_CYC);
			endcase
		end
	end

	assign unit_tick = (prescale_reg == unit_len - 1'b1);

	always_ff @(posedge clk_i) begin
		if (reset_i || state_reg != nfcfr_pkg::RX_DEAD || unit_tick) begin
			prescale_reg <= '0;
		end else begin
			prescale_reg <= prescale_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// Receive control
	// ----------------------------------------
	logic       multi;
	logic       emd_on;
	logic [1:0] byte_cnt_reg;
	logic       sof_frame_reg;
	logic       err_byte_pend_reg;
	logic       par_err;
	logic       emd_hit;
	logic       short_frame;
	logic       partial_ok;

	assign multi = rx_control_reg[nfcfr_pkg::RC_MULTI];
	assign emd_on = rx_control_reg[nfcfr_pkg::RC_EMD];
	assign par_err = frame_format_control_reg[nfcfr_pkg::FF_RX_PAR]
		&& (rx_parity_i == ~(^rx_byte_i)) == 1'b0;
	assign emd_hit = (state_reg == nfcfr_pkg::RX_ON) && emd_on
		&& (byte_cnt_reg < nfcfr_pkg::EMD_BYTES)
		&& ((rx_byte_valid_i && par_err) || rx_collision_i);
	assign short_frame = emd_on && sof_frame_reg
		&& (byte_cnt_reg < nfcfr_pkg::EMD_BYTES);
	assign partial_ok = (rx_bits_i != 3'h0)
		&& (!crc_enable_i || rx_control_reg[nfcfr_pkg::RC_ALLOW]);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= nfcfr_pkg::RX_OFF;
			dead_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				nfcfr_pkg::RX_OFF: begin
					if (tx_frame_end_i) begin
						state_reg <= nfcfr_pkg::RX_DEAD;
						dead_cnt_reg <= rx_dead_time_reg[nfcfr_pkg::DT_CNT_HI:nfcfr_pkg::DT_CNT_LO];
					end else if (rx_start_i) begin
						state_reg <= nfcfr_pkg::RX_ON;
					end
				end
				nfcfr_pkg::RX_DEAD: begin
					if (dead_cnt_reg == '0) begin
						state_reg <= nfcfr_pkg::RX_ON;
					end else if (unit_tick) begin
						dead_cnt_reg <= dead_cnt_reg - 1'b1;
					end
				end
				nfcfr_pkg::RX_ON: begin
					if (tx_frame_end_i) begin
						state_reg <= nfcfr_pkg::RX_DEAD;
						dead_cnt_reg <= rx_dead_time_reg[nfcfr_pkg::DT_CNT_HI:nfcfr_pkg::DT_CNT_LO];
					end else if (rx_frame_end_i && !multi && !short_frame) begin
						state_reg <= nfcfr_pkg::RX_OFF;
					end
				end
				default: state_reg <= nfcfr_pkg::RX_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			byte_cnt_reg <= '0;
			sof_frame_reg <= 1'b0;
		end else if (state_reg != nfcfr_pkg::RX_ON || rx_frame_end_i || emd_hit) begin
			byte_cnt_reg <= '0;
			sof_frame_reg <= 1'b0;
		end else begin
			if (rx_sof_i) begin
				sof_frame_reg <= 1'b1;
			end
			if (rx_byte_valid_i && byte_cnt_reg != nfcfr_pkg::EMD_BYTES) begin
				byte_cnt_reg <= byte_cnt_reg + 1'b1;
			end
		end
	end

	// FIFO writes: data bytes, partial byte, then the appended error byte
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fifo_wr_o <= 1'b0;
			fifo_wdata_o <= nfcfr_pkg::RESET_BYTE;
			fifo_flush_o <= 1'b0;
			err_byte_pend_reg <= 1'b0;
			rx_done_irq_o <= 1'b0;
			rx_parity_err_o <= 1'b0;
		end else begin
			fifo_wr_o <= 1'b0;
			fifo_flush_o <= 1'b0;
			rx_done_irq_o <= 1'b0;
			rx_parity_err_o <= 1'b0;
			if (state_reg == nfcfr_pkg::RX_ON && emd_hit) begin
				fifo_flush_o <= 1'b1;
			end else if (state_reg == nfcfr_pkg::RX_ON && rx_frame_end_i) begin
				if (short_frame) begin
					fifo_flush_o <= 1'b1;
				end else begin
					rx_done_irq_o <= 1'b1;
					err_byte_pend_reg <= multi;
					fifo_wr_o <= partial_ok;
					fifo_wdata_o <= rx_byte_i;
				end
			end else if (err_byte_pend_reg) begin
				err_byte_pend_reg <= 1'b0;
				fifo_wr_o <= 1'b1;
				fifo_wdata_o <= error_reg_i;
			end else if (state_reg == nfcfr_pkg::RX_ON && rx_byte_valid_i) begin
				fifo_wr_o <= 1'b1;
				fifo_wdata_o <= rx_byte_i;
				rx_parity_err_o <= par_err;
			end
		end
	end

	// ----------------------------------------
	// Guard time and end of frame
	// ----------------------------------------
	logic [15:0] egt_cnt_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i || !rx_guard_i) begin
			egt_cnt_reg <= '0;
		end else if (egt_cnt_reg != 16'hFFFF) begin
			egt_cnt_reg <= egt_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			protocol_err_o <= 1'b0;
			rx_enable_o <= 1'b0;
			rx_baud_o <= nfcfr_pkg::BAUD_106;
			eof_check_o <= 1'b0;
			eof_type_b_o <= 1'b0;
		end else begin
			protocol_err_o <= rx_control_reg[nfcfr_pkg::RC_EGT]
				&& rx_control_reg[nfcfr_pkg::RC_EOF_TYPE]
				&& (egt_cnt_reg == 16'(EGT_LIMIT_CYC));
			rx_enable_o <= (state_reg == nfcfr_pkg::RX_ON);
			rx_baud_o <= rx_control_reg[nfcfr_pkg::RC_BAUD_HI:nfcfr_pkg::RC_BAUD_LO];
			eof_type_b_o <= rx_control_reg[nfcfr_pkg::RC_EOF_TYPE];
			eof_check_o <= rx_control_reg[nfcfr_pkg::RC_EOF_TYPE]
				|| (end_symbol_register_i != 2'h0);
		end
	end

endmodule

// *** nfcfr_pkg.sv ***
package nfcfr_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_FRAME_FORMAT_CONTROL = 8'h33;
	localparam logic [7:0] ADDR_RX_FRAME_START_DETECT = 8'h34;
	localparam logic [7:0] ADDR_RX_CONTROL = 8'h35;
	localparam logic [7:0] ADDR_RX_DEAD_TIME = 8'h36;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FF_TX_PAR = 7;
	localparam int FF_RX_PAR = 6;
	localparam int FF_STOP_HI = 3;
	localparam int FF_STOP_LO = 2;
	localparam int FF_START_HI = 1;
	localparam int FF_START_LO = 0;
	localparam int SD_SOF_EN = 5;
	localparam int SD_SOF_SEEN = 4;
	localparam int SD_SUBCARRIER_IRQ_ENABLE = 2;
	localparam int SD_SUBC_SEEN = 1;
	localparam int SD_SUBC_NOW = 0;
	localparam int RC_ALLOW = 7;
	localparam int RC_MULTI = 6;
	localparam int RC_EOF_TYPE = 5;
	localparam int RC_EGT = 4;
	localparam int RC_EMD = 3;
	localparam int RC_BAUD_HI = 2;
	localparam int RC_BAUD_LO = 0;
	localparam int DT_UNIT = 7;
	localparam int DT_CNT_HI = 6;
	localparam int DT_CNT_LO = 0;

	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] FF_MASK = 8'hCF;
	localparam logic [7:0] SD_MASK = 8'h24;
	localparam logic [1:0] SYM_NONE = 2'h0;
	localparam logic [2:0] BAUD_106 = 3'h4;
	localparam logic [2:0] BAUD_212 = 3'h5;
	localparam logic [2:0] BAUD_424 = 3'h6;
	localparam logic [2:0] BAUD_847 = 3'h7;
	localparam logic [1:0] EMD_BYTES = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_KHZ = 200000;
	localparam int CARRIER_KHZ = 13560;
	localparam int UNIT_CARRIER_PERIODS = 16;
	localparam int HALF_BIT_106_PERIODS = 64;
	localparam int UNIT16_CYC =
		(UNIT_CARRIER_PERIODS * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
	localparam int HALF_106_CYC =
		(HALF_BIT_106_PERIODS * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
	localparam int HALF_212_CYC =
		(HALF_BIT_106_PERIODS / 2 * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
	localparam int HALF_424_CYC =
		(HALF_BIT_106_PERIODS / 4 * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
	localparam int HALF_847_CYC =
		(HALF_BIT_106_PERIODS / 8 * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
	localparam int PRESCALE_W = 10;

	typedef enum logic [1:0] {
		RX_OFF,
		RX_DEAD,
		RX_ON
	} nfcfr_rx_state_t;

endpackage
